// file: hdl/lmh_pkg.sv
// Constants and types shared by the LED matrix host interface.
// Assumes a 250 MHz system clock; all counts derive from it.
package lmh_pkg;
  // Clocking
  localparam int CLK_HZ = 250_000_000;
  localparam int OSC_HZ = 256_000;
  // Half period of the on-chip oscillator, rounded down
  localparam int OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
  localparam int OSC_CNT_W = 10;

  // Display geometry
  localparam int RAM_DEPTH = 88;
  localparam int NIB_W = 4;
  localparam int ADDR_W = 7;
  localparam int ROW_N = 44;
  localparam int COM_N = 8;
  localparam int COM_W = 3;
  localparam int NIB_PER_COM = ROW_N / NIB_W;
  localparam int LVL_W = 4;
  localparam logic [LVL_W-1:0] LVL_MAX = 4'hf;
  localparam logic [LVL_W-1:0] BRIGHT_RST = 4'hf;

  // Serial framing
  localparam int ID_BITS = 3;
  localparam int CMD_BITS = 8;
  localparam int SH_W = 8;
  localparam int CNT_W = 4;
  localparam logic [2:0] ID_CMD = 3'h4;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_READ = 3'h6;
  localparam logic [7:0] CMD_SLAVE = 8'h10;
  localparam logic [7:0] CMD_INT_OSC_LEAD = 8'h18;
  localparam logic [7:0] CMD_EXT_CLK_LEAD = 8'h1c;
  localparam logic [3:0] CMD_BRIGHT_HI = 4'ha;

  // Positions of the pins in the synchroniser vector
  localparam int PIN_CS = 0;
  localparam int PIN_WR = 1;
  localparam int PIN_RD = 2;
  localparam int PIN_DAT = 3;
  localparam int PIN_OSC = 4;
  localparam int PIN_SYNC = 5;
  localparam int PIN_VAR = 6;
  localparam int PIN_N = 7;

  typedef enum logic [2:0] {
    ST_ID = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h2,
    ST_WDATA = 3'h3,
    ST_RDATA = 3'h4,
    ST_HALT = 3'h5
  } lmh_state_t;

  typedef enum logic [1:0] {
    MODE_SLAVE = 2'h0,
    MODE_INTERNAL_OSC_LEAD = 2'h1,
    MODE_EXTERNAL_CLOCK_LEAD = 2'h2
  } lmh_mode_t;
endpackage : lmh_pkg

// file: hdl/lmh_host_if.sv
// Host front end of the LED matrix controller: four-wire serial port,
// display memory, brightness PWM, row/common scan, clock and sync pins.
// Assumes all pins are asynchronous to clk_sys and much slower than it.
// Overview of operation
// RL1 - Serial data is shifted in on each write clock rising edge.
// RL2 - During a read, each read clock falling edge puts the next bit out.
// RL3 - Host may capture each read bit on the following read clock rise.
// RL4 - Chip select high blocks all transfers and resets the serial logic.
// RL5 - Transfers happen only while chip select is held low.
// RL6 - Internal oscillator lead mode runs from 256 kHz and drives it out.
// RL7 - Slave or external clock lead mode takes the oscillator pin as input.
// RL8 - Both lead modes drive the synchronisation signal out.
// RL9 - Slave mode takes its synchronisation from the sync pin.
// RL10 - In the two-wire variant read clock and chip select are address pins.
// RL11 - Display contents live in an 88 by 4 bit memory.
// RL12 - Global brightness has 16 PWM levels set by command.
// RL13 - 44 rows are scanned against 8 commons, 352 points.
// RL14 - Command instructions configure; data instructions reach memory.
// RL15 - Cascaded slaves follow the lead clock and sync to stay aligned.
`timescale 1ns/10ps
`default_nettype none
module lmh_host_if #(
  parameter int OSC_HALF = lmh_pkg::OSC_HALF_CYC,
  parameter int BUF_DEPTH = 2
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Variant strap, high selects the address-pin variant
  input wire logic i2cVariant,
  // Four-wire serial pins
  input wire logic chipSelectN,
  input wire logic writeClockIn,
  input wire logic readClockIn,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  // Device address pins
  output logic devAddrBitLow,
  output logic devAddrBitHigh,
  // Clock and cascade pins
  input wire logic oscIn,
  output logic oscOut,
  output logic oscOe,
  input wire logic syncIn,
  output logic syncOut,
  output logic syncOe,
  // Display drive
  output logic [lmh_pkg::ROW_N-1:0] rowOutputs,
  output logic [lmh_pkg::COM_N-1:0] commonOutputs
);
  localparam int PTR_W = (BUF_DEPTH > 2) ? $clog2(BUF_DEPTH) : 1;
  localparam int BCNT_W = $clog2(BUF_DEPTH + 1);
  localparam int WORD_W = lmh_pkg::ADDR_W + lmh_pkg::NIB_W;

  function automatic logic [lmh_pkg::ADDR_W-1:0] addrNext(
    input logic [lmh_pkg::ADDR_W-1:0] a);
    if (a >= lmh_pkg::ADDR_W'(lmh_pkg::RAM_DEPTH - 1)) return '0;
    return a + 1'b1;
  endfunction : addrNext

  function automatic logic [PTR_W-1:0] ptrNext(input logic [PTR_W-1:0] p);
    if (p == PTR_W'(BUF_DEPTH - 1)) return '0;
    return p + 1'b1;
  endfunction : ptrNext

  // Pin synchronisers; stage one feeds only stage two
  logic [lmh_pkg::PIN_N-1:0] rawPins, pinMeta_ff, pinSync_ff, pinPrev_ff;
  // Pulled-up pins reset high so no false clock edge follows reset
  localparam logic [lmh_pkg::PIN_N-1:0] PIN_IDLE =
    (lmh_pkg::PIN_N'(1) << lmh_pkg::PIN_CS) |
    (lmh_pkg::PIN_N'(1) << lmh_pkg::PIN_WR) |
    (lmh_pkg::PIN_N'(1) << lmh_pkg::PIN_RD) |
    (lmh_pkg::PIN_N'(1) << lmh_pkg::PIN_DAT);
  assign rawPins[lmh_pkg::PIN_CS] = chipSelectN;
  assign rawPins[lmh_pkg::PIN_WR] = writeClockIn;
  assign rawPins[lmh_pkg::PIN_RD] = readClockIn;
  assign rawPins[lmh_pkg::PIN_DAT] = dataIn;
  assign rawPins[lmh_pkg::PIN_OSC] = oscIn;
  assign rawPins[lmh_pkg::PIN_SYNC] = syncIn;
  assign rawPins[lmh_pkg::PIN_VAR] = i2cVariant;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinMeta_ff <= PIN_IDLE;
      pinSync_ff <= PIN_IDLE;
      pinPrev_ff <= PIN_IDLE;
    end else if (clkEn) begin
      pinMeta_ff <= rawPins;
      pinSync_ff <= pinMeta_ff;
      pinPrev_ff <= pinSync_ff;
    end
  end

  logic serialOff, wrRise, rdFall, oscRise, syncRise, din;
  assign din = pinSync_ff[lmh_pkg::PIN_DAT];
  assign serialOff = pinSync_ff[lmh_pkg::PIN_CS] |
                     pinSync_ff[lmh_pkg::PIN_VAR];
  assign wrRise = pinSync_ff[lmh_pkg::PIN_WR] & ~pinPrev_ff[lmh_pkg::PIN_WR];
  assign rdFall = ~pinSync_ff[lmh_pkg::PIN_RD] & pinPrev_ff[lmh_pkg::PIN_RD];
  assign oscRise = pinSync_ff[lmh_pkg::PIN_OSC] &
                   ~pinPrev_ff[lmh_pkg::PIN_OSC];
  assign syncRise = pinSync_ff[lmh_pkg::PIN_SYNC] &
                    ~pinPrev_ff[lmh_pkg::PIN_SYNC];

  // Serial state
  lmh_pkg::lmh_state_t state_ff, nxt_state;
  lmh_pkg::lmh_mode_t mode_ff, nxt_mode;
  logic [lmh_pkg::SH_W-1:0] shReg_ff, nxt_shReg, shiftIn;
  logic [lmh_pkg::CNT_W-1:0] bitCnt_ff, nxt_bitCnt;
  logic [lmh_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
  logic [lmh_pkg::NIB_W-1:0] rdNib_ff, nxt_rdNib;
  logic [1:0] rdBit_ff, nxt_rdBit;
  logic [lmh_pkg::LVL_W-1:0] bright_ff, nxt_bright;
  logic [WORD_W-1:0] pendWord_ff, nxt_pendWord;
  logic isRead_ff, nxt_isRead, pendValid_ff, nxt_pendValid;
  logic dataOut_ff, nxt_dataOut, dataOe_ff, nxt_dataOe;
  logic addrLow_ff, addrHigh_ff, rdFetch, bufInReady;
  logic [lmh_pkg::NIB_W-1:0] ram_ff [lmh_pkg::RAM_DEPTH];
  logic [lmh_pkg::NIB_W-1:0] nxt_ram [lmh_pkg::RAM_DEPTH];

  always_comb begin
    nxt_state = state_ff;
    nxt_mode = mode_ff;
    nxt_shReg = shReg_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_isRead = isRead_ff;
    nxt_addr = addr_ff;
    nxt_rdNib = rdNib_ff;
    nxt_rdBit = rdBit_ff;
    nxt_dataOut = dataOut_ff;
    nxt_dataOe = dataOe_ff;
    nxt_bright = bright_ff;
    nxt_pendValid = pendValid_ff & ~bufInReady;
    nxt_pendWord = pendWord_ff;
    rdFetch = 1'b0;
    shiftIn = {shReg_ff[lmh_pkg::SH_W-2:0], din};
    if (serialOff) begin
      nxt_state = lmh_pkg::ST_ID; // [RL4] [RL5] [RL10]
      nxt_bitCnt = '0;
      nxt_rdBit = '0;
      nxt_dataOe = 1'b0;
    end else if (wrRise && state_ff != lmh_pkg::ST_RDATA) begin
      nxt_shReg = shiftIn; // [RL1]
      nxt_bitCnt = bitCnt_ff + 1'b1;
      case (state_ff)
        lmh_pkg::ST_ID: begin
          if (bitCnt_ff == lmh_pkg::CNT_W'(lmh_pkg::ID_BITS - 1)) begin
            nxt_bitCnt = '0;
            nxt_isRead = (shiftIn[2:0] == lmh_pkg::ID_READ);
            case (shiftIn[2:0]) // [RL14]
              lmh_pkg::ID_CMD: nxt_state = lmh_pkg::ST_CMD;
              lmh_pkg::ID_WRITE: nxt_state = lmh_pkg::ST_ADDR;
              lmh_pkg::ID_READ: nxt_state = lmh_pkg::ST_ADDR;
              default: nxt_state = lmh_pkg::ST_HALT;
            endcase
          end
        end
        lmh_pkg::ST_CMD: begin
          if (bitCnt_ff == lmh_pkg::CNT_W'(lmh_pkg::CMD_BITS - 1)) begin
            nxt_bitCnt = '0;
            case (shiftIn) // [RL14]
              lmh_pkg::CMD_SLAVE: nxt_mode = lmh_pkg::MODE_SLAVE;
              lmh_pkg::CMD_INT_OSC_LEAD:
                nxt_mode = lmh_pkg::MODE_INTERNAL_OSC_LEAD;
              lmh_pkg::CMD_EXT_CLK_LEAD:
                nxt_mode = lmh_pkg::MODE_EXTERNAL_CLOCK_LEAD;
              default: begin
                if (shiftIn[7:4] == lmh_pkg::CMD_BRIGHT_HI)
                  nxt_bright = shiftIn[3:0]; // [RL12]
              end
            endcase
          end
        end
        lmh_pkg::ST_ADDR: begin
          if (bitCnt_ff == lmh_pkg::CNT_W'(lmh_pkg::ADDR_W - 1)) begin
            nxt_bitCnt = '0;
            nxt_addr = shiftIn[lmh_pkg::ADDR_W-1:0];
            if (isRead_ff) begin
              nxt_state = lmh_pkg::ST_RDATA;
              rdFetch = 1'b1;
              nxt_rdNib = (nxt_addr < lmh_pkg::ADDR_W'(lmh_pkg::RAM_DEPTH)) ?
                          ram_ff[nxt_addr] : '0;
            end else begin
              nxt_state = lmh_pkg::ST_WDATA;
            end
          end
        end
        lmh_pkg::ST_WDATA: begin
          if (bitCnt_ff == lmh_pkg::CNT_W'(lmh_pkg::NIB_W - 1)) begin
            nxt_bitCnt = '0;
            nxt_pendValid = 1'b1; // [RL11]
            nxt_pendWord = {addr_ff, shiftIn[lmh_pkg::NIB_W-1:0]};
            nxt_addr = addrNext(addr_ff);
          end
        end
        default: nxt_bitCnt = bitCnt_ff;
      endcase
    end else if (rdFall && state_ff == lmh_pkg::ST_RDATA) begin
      // Host samples on the next read clock rise [RL3]
      nxt_dataOut = rdNib_ff[2'(lmh_pkg::NIB_W - 1) - rdBit_ff]; // [RL2]
      nxt_dataOe = 1'b1;
      nxt_rdBit = rdBit_ff + 1'b1;
      if (rdBit_ff == 2'(lmh_pkg::NIB_W - 1)) begin
        nxt_addr = addrNext(addr_ff);
        nxt_rdNib = ram_ff[addrNext(addr_ff)];
        rdFetch = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= lmh_pkg::ST_ID;
      mode_ff <= lmh_pkg::MODE_INTERNAL_OSC_LEAD;
      shReg_ff <= '0;
      bitCnt_ff <= '0;
      isRead_ff <= 1'b0;
      addr_ff <= '0;
      rdNib_ff <= '0;
      rdBit_ff <= '0;
      dataOut_ff <= 1'b0;
      dataOe_ff <= 1'b0;
      bright_ff <= lmh_pkg::BRIGHT_RST;
      pendValid_ff <= 1'b0;
      pendWord_ff <= '0;
      addrLow_ff <= 1'b0;
      addrHigh_ff <= 1'b0;
    end else if (clkEn) begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      shReg_ff <= nxt_shReg;
      bitCnt_ff <= nxt_bitCnt;
      isRead_ff <= nxt_isRead;
      addr_ff <= nxt_addr;
      rdNib_ff <= nxt_rdNib;
      rdBit_ff <= nxt_rdBit;
      dataOut_ff <= nxt_dataOut;
      dataOe_ff <= nxt_dataOe;
      bright_ff <= nxt_bright;
      pendValid_ff <= nxt_pendValid;
      pendWord_ff <= nxt_pendWord;
      // Address pins read as zero in the four-wire variant [RL10]
      addrLow_ff <= pinSync_ff[lmh_pkg::PIN_VAR] & pinSync_ff[lmh_pkg::PIN_CS];
      addrHigh_ff <= pinSync_ff[lmh_pkg::PIN_VAR] & pinSync_ff[lmh_pkg::PIN_RD];
    end
  end

  // Write buffer into display memory; drain yields to read fetches,
  // which models a single-port memory with one access per cycle
  logic [WORD_W-1:0] buf_ff [BUF_DEPTH];
  logic [WORD_W-1:0] nxt_buf [BUF_DEPTH];
  logic [WORD_W-1:0] drainWord;
  logic [PTR_W-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [BCNT_W-1:0] cnt_ff, nxt_cnt;
  logic push, drain;
  assign bufInReady = (cnt_ff != BCNT_W'(BUF_DEPTH));

  always_comb begin
    nxt_ram = ram_ff;
    nxt_buf = buf_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    push = pendValid_ff && bufInReady;
    drain = (cnt_ff != '0) && !rdFetch;
    drainWord = buf_ff[rp_ff];
    if (push) begin
      nxt_buf[wp_ff] = pendWord_ff;
      nxt_wp = ptrNext(wp_ff);
    end
    if (drain) begin
      nxt_rp = ptrNext(rp_ff);
      if (drainWord[WORD_W-1:lmh_pkg::NIB_W] <
          lmh_pkg::ADDR_W'(lmh_pkg::RAM_DEPTH))
        nxt_ram[drainWord[WORD_W-1:lmh_pkg::NIB_W]] =
          drainWord[lmh_pkg::NIB_W-1:0]; // [RL11]
    end
    nxt_cnt = cnt_ff + BCNT_W'(push) - BCNT_W'(drain);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < lmh_pkg::RAM_DEPTH; i++) ram_ff[i] <= '0;
      for (int i = 0; i < BUF_DEPTH; i++) buf_ff[i] <= '0;
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else if (clkEn) begin
      ram_ff <= nxt_ram;
      buf_ff <= nxt_buf;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Clock source, sync and scan
  logic [lmh_pkg::OSC_CNT_W-1:0] oscCnt_ff, nxt_oscCnt;
  logic [lmh_pkg::LVL_W-1:0] pwm_ff, nxt_pwm;
  logic [lmh_pkg::COM_W-1:0] com_ff, nxt_com;
  logic [lmh_pkg::ROW_N-1:0] rows_ff, nxt_rows;
  logic [lmh_pkg::COM_N-1:0] coms_ff, nxt_coms;
  logic oscLvl_ff, nxt_oscLvl, syncOut_ff, syncOe_ff, oscOe_ff, tick;
  logic isInt, isSlave;
  assign isInt = (mode_ff == lmh_pkg::MODE_INTERNAL_OSC_LEAD);
  assign isSlave = (mode_ff == lmh_pkg::MODE_SLAVE);

  always_comb begin
    nxt_oscCnt = '0;
    nxt_oscLvl = 1'b0;
    nxt_pwm = pwm_ff;
    nxt_com = com_ff;
    tick = oscRise; // [RL7]
    if (isInt) begin
      tick = 1'b0;
      nxt_oscLvl = oscLvl_ff;
      nxt_oscCnt = oscCnt_ff + 1'b1;
      if (oscCnt_ff == lmh_pkg::OSC_CNT_W'(OSC_HALF - 1)) begin
        nxt_oscCnt = '0; // [RL6]
        nxt_oscLvl = ~oscLvl_ff;
        tick = ~oscLvl_ff;
      end
    end
    if (isSlave && syncRise) begin
      nxt_pwm = '0; // [RL9] [RL15]
      nxt_com = '0;
    end else if (tick) begin
      nxt_pwm = pwm_ff + 1'b1;
      if (pwm_ff == lmh_pkg::LVL_MAX)
        nxt_com = (com_ff == lmh_pkg::COM_W'(lmh_pkg::COM_N - 1)) ?
                  '0 : com_ff + 1'b1;
    end
    for (int r = 0; r < lmh_pkg::ROW_N; r++)
      nxt_rows[r] = (pwm_ff <= bright_ff) && // [RL12] [RL13]
        ram_ff[int'(com_ff) * lmh_pkg::NIB_PER_COM + r / lmh_pkg::NIB_W]
              [r % lmh_pkg::NIB_W];
    nxt_coms = '0;
    nxt_coms[com_ff] = 1'b1; // [RL13]
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oscCnt_ff <= '0;
      oscLvl_ff <= 1'b0;
      pwm_ff <= '0;
      com_ff <= '0;
      rows_ff <= '0;
      coms_ff <= '0;
      oscOe_ff <= 1'b0;
      syncOut_ff <= 1'b0;
      syncOe_ff <= 1'b0;
    end else if (clkEn) begin
      oscCnt_ff <= nxt_oscCnt;
      oscLvl_ff <= nxt_oscLvl;
      pwm_ff <= nxt_pwm;
      com_ff <= nxt_com;
      rows_ff <= nxt_rows;
      coms_ff <= nxt_coms;
      oscOe_ff <= isInt; // [RL6] [RL7]
      // Sync is high for the whole common-0 slot; slaves align on its rise
      syncOut_ff <= !isSlave && (com_ff == '0);
      syncOe_ff <= !isSlave; // [RL8] [RL9]
    end
  end

  assign dataOut = dataOut_ff;
  assign dataOe = dataOe_ff;
  assign devAddrBitLow = addrLow_ff;
  assign devAddrBitHigh = addrHigh_ff;
  assign oscOut = oscLvl_ff;
  assign oscOe = oscOe_ff;
  assign syncOut = syncOut_ff;
  assign syncOe = syncOe_ff;
  assign rowOutputs = rows_ff;
  assign commonOutputs = coms_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  cs_reset_a: assert property (clkEn && serialOff |=> // [RL4]
    state_ff == lmh_pkg::ST_ID && bitCnt_ff == '0 && !dataOe_ff)
    else $error("serial logic not reset by chip select");
  wr_sample_a: assert property (clkEn && !serialOff && wrRise && // [RL1]
    state_ff != lmh_pkg::ST_RDATA |=> shReg_ff[0] == $past(din))
    else $error("data bit not sampled on write clock rise");
  rd_drive_a: assert property (clkEn && !serialOff && rdFall && // [RL2]
    state_ff == lmh_pkg::ST_RDATA |=> dataOe_ff &&
    dataOut_ff == $past(rdNib_ff[2'(lmh_pkg::NIB_W - 1) - rdBit_ff]))
    else $error("read bit not driven on read clock fall");
  osc_lead_a: assert property (clkEn && isInt ##1 clkEn |-> oscOe_ff) // [RL6]
    else $error("oscillator pin not driven in internal mode");
  osc_input_a: assert property (clkEn && !isInt |=> !oscOe_ff) // [RL7]
    else $error("oscillator pin driven while an input");
  sync_drive_a: assert property (clkEn && !isSlave |=> syncOe_ff) // [RL8]
    else $error("sync pin not driven in lead mode");
  slave_sync_a: assert property (clkEn && isSlave && syncRise |=> // [RL9]
    pwm_ff == '0 && com_ff == '0 && !syncOe_ff)
    else $error("slave did not align to sync");
  addr_pin_a: assert property (clkEn && pinSync_ff[lmh_pkg::PIN_VAR] // [RL10]
    |=> state_ff == lmh_pkg::ST_ID && addrHigh_ff ==
    $past(pinSync_ff[lmh_pkg::PIN_RD]))
    else $error("address pins not honoured in two-wire variant");
  ram_write_a: assert property (clkEn && drain && // [RL11]
    drainWord[WORD_W-1:lmh_pkg::NIB_W] == '0 |=>
    ram_ff[0] == $past(drainWord[lmh_pkg::NIB_W-1:0]))
    else $error("buffered nibble not written to memory");
  pwm_off_a: assert property (clkEn && pwm_ff > bright_ff |=> // [RL12]
    rows_ff == '0)
    else $error("rows lit outside brightness window");
  com_hot_a: assert property ($onehot0(coms_ff)) // [RL13]
    else $error("more than one common active");
  cover property (clkEn && push ##[1:4] drain);
  cover property (clkEn && rdFall && state_ff == lmh_pkg::ST_RDATA);
  cover property (clkEn && isSlave && syncRise);
  cover property (cnt_ff == BCNT_W'(BUF_DEPTH));
endmodule : lmh_host_if
`default_nettype wire

// file: testbench/lmh_host_model.sv
// Host controller model driving the four-wire serial pins.
// Assumes the bench resolves the data pin with its pull-up.
`timescale 1ns/10ps
`default_nettype none
module lmh_host_model #(
  parameter int HALF = 20
) (
  // Pacing clock
  input wire logic clk_sys,
  // Serial pins
  output logic chipSelectN,
  output logic writeClockIn,
  output logic readClockIn,
  output logic hostData,
  output logic hostOe,
  input wire logic pinData
);
  int slow = 1;
  logic csLevel = 1'b0;
  initial begin
    chipSelectN = 1'b1;
    writeClockIn = 1'b1;
    readClockIn = 1'b1;
    hostData = 1'b1;
    hostOe = 1'b0;
  end
  task automatic half_wait();
    repeat (HALF * slow) @(negedge clk_sys);
  endtask : half_wait
  // Data changes with the falling write clock, stable across the rise
  task automatic put_bit(input logic b);
    writeClockIn = 1'b0;
    hostData = b;
    hostOe = 1'b1;
    half_wait();
    writeClockIn = 1'b1;
    half_wait();
  endtask : put_bit
  task automatic get_bit(output logic b);
    readClockIn = 1'b0;
    half_wait();
    readClockIn = 1'b1;
    b = pinData;
    half_wait();
  endtask : get_bit
  task automatic open_frame(input logic [2:0] id);
    chipSelectN = csLevel;
    half_wait();
    for (int i = 2; i >= 0; i--) put_bit(id[i]);
  endtask : open_frame
  task automatic close_frame();
    hostOe = 1'b0;
    half_wait();
    chipSelectN = 1'b1;
    half_wait();
    half_wait();
  endtask : close_frame
  task automatic put_addr(input logic [6:0] a);
    for (int i = 6; i >= 0; i--) put_bit(a[i]);
  endtask : put_addr
  task automatic send_cmd(input logic [7:0] c);
    open_frame(lmh_pkg::ID_CMD);
    for (int i = 7; i >= 0; i--) put_bit(c[i]);
    close_frame();
  endtask : send_cmd
  // Two whole nibbles, first one at the given address
  task automatic write_pair(input logic [6:0] a, input logic [7:0] d);
    open_frame(lmh_pkg::ID_WRITE);
    put_addr(a);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    close_frame();
  endtask : write_pair
  task automatic read_pair(input logic [6:0] a, output logic [7:0] d);
    open_frame(lmh_pkg::ID_READ);
    put_addr(a);
    hostOe = 1'b0;
    half_wait();
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    close_frame();
  endtask : read_pair
  task automatic set_pins(input logic cs, input logic rd);
    chipSelectN = cs;
    readClockIn = rd;
  endtask : set_pins
endmodule : lmh_host_model
`default_nettype wire

// file: testbench/lmh_host_if_tb.sv
// Self-checking bench for the LED matrix host front end.
// Assumes the oscillator half period is shortened to OSCH cycles.
`timescale 1ns/10ps
`default_nettype none
module lmh_host_if_tb;
  localparam int OSCH = 4;
  typedef struct packed {
    logic [7:0] cmd;
    logic oe;
    logic so;
  } lmh_row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic i2cVariant = 1'b0;
  logic oscIn = 1'b0;
  logic syncIn = 1'b0;
  logic chipSelectN, writeClockIn, readClockIn, hostData, hostOe;
  logic dataOut, dataOe, devAddrBitLow, devAddrBitHigh;
  logic oscOut, oscOe, syncOut, syncOe;
  logic [lmh_pkg::ROW_N-1:0] rowOutputs;
  logic [lmh_pkg::COM_N-1:0] commonOutputs;
  wire logic pinData;
  int n_mismatch = 0;
  int cmp_count = 0;
  lmh_row_t rows [3] = '{
    '{lmh_pkg::CMD_EXT_CLK_LEAD, 1'b0, 1'b1},
    '{lmh_pkg::CMD_INT_OSC_LEAD, 1'b1, 1'b1},
    '{lmh_pkg::CMD_SLAVE, 1'b0, 1'b0}};
  // Pull-up holds the data pin when nobody drives it
  assign pinData = dataOe ? dataOut : (hostOe ? hostData : 1'b1);
  lmh_host_if #(.OSC_HALF(OSCH), .BUF_DEPTH(2)) lmh_host_if_inst (
    .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .i2cVariant(i2cVariant),
    .chipSelectN(chipSelectN), .writeClockIn(writeClockIn),
    .readClockIn(readClockIn), .dataIn(pinData), .dataOut(dataOut),
    .dataOe(dataOe), .devAddrBitLow(devAddrBitLow),
    .devAddrBitHigh(devAddrBitHigh), .oscIn(oscIn), .oscOut(oscOut),
    .oscOe(oscOe), .syncIn(syncIn), .syncOut(syncOut), .syncOe(syncOe),
    .rowOutputs(rowOutputs), .commonOutputs(commonOutputs)
  );
  lmh_host_model #(.HALF(20)) lmh_host_model_inst (
    .clk_sys(clk_sys), .chipSelectN(chipSelectN),
    .writeClockIn(writeClockIn), .readClockIn(readClockIn),
    .hostData(hostData), .hostOe(hostOe), .pinData(pinData)
  );
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // Cycles between two changes of the oscillator pin
  task automatic osc_half(output int n);
    logic o;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      o = oscOut;
      while (oscOut === o && n < 100) begin
        @(negedge clk_sys);
        n++;
      end
    end
  endtask : osc_half
  task automatic pulse_osc();
    oscIn = 1'b1;
    repeat (4) @(negedge clk_sys);
    oscIn = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : pulse_osc
  // Whole run is near 10.5k cycles; this allows more than four times that
  initial begin
    #200_000;
    n_mismatch++;
    test_done();
  end
  initial begin
    logic [7:0] c;
    logic [7:0] d;
    int n;
    int ci;
    repeat (16) @(negedge clk_sys);
    check("oscOe in reset", oscOe, 1'b0);
    check("syncOe in reset", syncOe, 1'b0);
    check("commons in reset", commonOutputs, 8'h00);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    check("oscOe after reset", oscOe, 1'b1);
    check("syncOe after reset", syncOe, 1'b1);
    check("syncOut after reset", syncOut, 1'b1);
    check("commons after reset", commonOutputs, 8'h01);
    foreach (rows[i]) begin
      lmh_host_model_inst.send_cmd(rows[i].cmd);
      check("oscOe per mode", oscOe, rows[i].oe);
      check("syncOe per mode", syncOe, rows[i].so);
      if (rows[i].oe) begin
        osc_half(n);
        check("osc half period", n, OSCH);
      end
    end
    // Slave mode: scan moves only with the outside clock
    c = commonOutputs;
    repeat (100) @(negedge clk_sys);
    check("commons frozen", commonOutputs, c);
    repeat (16) pulse_osc();
    repeat (10) @(negedge clk_sys);
    check("commons step", commonOutputs, {c[6:0], c[7]});
    c = commonOutputs;
    check("one hot commons", $countones(c), 1);
    ci = 0;
    for (int i = 0; i < 8; i++) begin
      if (c[i]) ci = i;
    end
    lmh_host_model_inst.write_pair(7'(ci * 11), 8'h96);
    check("rows of common", rowOutputs[7:0], 8'h69);
    lmh_host_model_inst.csLevel = 1'b1;
    lmh_host_model_inst.write_pair(7'(ci * 11), 8'h00);
    lmh_host_model_inst.csLevel = 1'b0;
    check("rows kept", rowOutputs[7:0], 8'h69);
    lmh_host_model_inst.read_pair(7'(ci * 11), d);
    check("read back", d, 8'h96);
    check("data pin released", dataOe, 1'b0);
    // Slow host across the wrap from the last address
    lmh_host_model_inst.slow = 3;
    lmh_host_model_inst.write_pair(7'd87, 8'h5c);
    lmh_host_model_inst.read_pair(7'd87, d);
    lmh_host_model_inst.slow = 1;
    check("wrap read", d, 8'h5c);
    // Second nibble wraps to address 0, which holds the wrap write
    lmh_host_model_inst.read_pair(7'd88, d);
    check("beyond memory", d, 8'h0c);
    // Slave aligns to sync; brightness 0 lights rows only at pwm 0
    syncIn = 1'b1;
    repeat (6) @(negedge clk_sys);
    syncIn = 1'b0;
    check("commons on sync", commonOutputs, 8'h01);
    check("sync pin in slave", {syncOe, syncOut}, 2'b00);
    lmh_host_model_inst.send_cmd({lmh_pkg::CMD_BRIGHT_HI, 4'h0});
    check("rows at pwm 0", rowOutputs[3:0], 4'hc);
    pulse_osc();
    check("rows dimmed", rowOutputs[3:0], 4'h0);
    i2cVariant = 1'b1;
    for (int i = 0; i < 4; i++) begin
      lmh_host_model_inst.set_pins(i[0], i[1]);
      repeat (6) @(negedge clk_sys);
      check("addr low pin", devAddrBitLow, i[0]);
      check("addr high pin", devAddrBitHigh, i[1]);
    end
    lmh_host_model_inst.set_pins(1'b1, 1'b1);
    i2cVariant = 1'b0;
    repeat (6) @(negedge clk_sys);
    check("addr pins off", {devAddrBitHigh, devAddrBitLow}, 2'b00);
    test_done();
  end
endmodule : lmh_host_if_tb
`default_nettype wire
